// *** design/gpio_port.sv ***
// Purpose: sixteen-pin general-purpose port with delta status and event generation
// Assumes: simple configuration bus, request taken in one cycle, answer one cycle later
// Notes:   pins are input, output and active-low output enable signals
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port_regs.svh"
module gpio_port
   import gpio_port_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic cfg_req,
   input wire logic cfg_wr,
   input wire logic [31:0] cfg_addr,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_ack,
   input wire pins_t general_pin_bus_in,
   output pins_t general_pin_bus_out,
   output pins_t general_pin_bus_oe_n,
   output logic cpu_irq_req,
   output logic dma_event_req
);
   port_state_s st_reg;
   port_state_s st_next;
   pin_edge_if edges();

   pin_edge_detect u_detect
   (
      .clk(clk),
      .rstn(rstn),
      .pin_in(general_pin_bus_in),
      .edges(edges)
   );

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // write-one-to-clear with a new edge winning over the clear
   function automatic pins_t w1c_update(pins_t cur, pins_t set, logic wr, pins_t wdat);
      pins_t cleared;
      cleared = wr ? (cur & ~wdat) : cur;
      return cleared | set;
   endfunction

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   pins_t in_pins;
   pins_t out_pins;
   pins_t active;
   pins_t pass_hit;
   logic cond_or;
   logic cond_and;
   logic cond_now;
   logic evt;
   logic wr_hit;
   event_mode_e mode;

   always_comb
   begin
      st_next = st_reg;
      // disabled pins stay inputs whatever the direction bit says [R1] [R3]
      out_pins = st_reg.en_reg & st_reg.dir_reg; // [R2]
      in_pins = st_reg.en_reg & ~st_reg.dir_reg; // [R2]
      mode = event_mode_e'(st_reg.gc_reg[`GC_MODE_MSB:`GC_MODE_LSB]);
      wr_hit = cfg_req & cfg_wr;

      // delta bits latch edges of enabled inputs only [R10]
      st_next.rise_stat_reg = w1c_update(st_reg.rise_stat_reg, edges.rise & in_pins,
         wr_hit && cfg_addr == `RISE_STATUS_OFS, cfg_wdata[15:0]);
      st_next.fall_stat_reg = w1c_update(st_reg.fall_stat_reg, edges.fall & in_pins,
         wr_hit && cfg_addr == `FALL_STATUS_OFS, cfg_wdata[15:0]);

      // pass mode: any masked edge of an enabled input is an event; logic modes combine active levels [R7] [R10]
      pass_hit = ((edges.rise & st_reg.rise_mask_reg) | (edges.fall & st_reg.fall_mask_reg))
         & in_pins;
      active = (edges.level ^ st_reg.pol_reg) & in_pins; // [R10]
      cond_or = |(active & st_reg.rise_mask_reg);
      cond_and = (st_reg.rise_mask_reg != 16'h0000)
         && ((active & st_reg.rise_mask_reg) == st_reg.rise_mask_reg);
      case (mode)
         MODE_OR:
            cond_now = cond_or;
         MODE_AND:
            cond_now = cond_and;
         default:
            cond_now = 1'b0;
      endcase
      st_next.cond_prev_reg = cond_now;
      // logic modes fire once as the combined condition becomes true
      evt = (mode == MODE_PASS) ? (|pass_hit) : (cond_now & ~st_reg.cond_prev_reg);
      st_next.irq_reg = evt & st_reg.gc_reg[`GC_IRQ_EN_BIT]; // [R7]
      st_next.dma_reg = evt & st_reg.gc_reg[`GC_DMA_EN_BIT]; // [R7]

      // ------------------------------------------------------------
      // register writes
      // ------------------------------------------------------------
      if (wr_hit)
      begin
         if (cfg_addr == `PIN_ENABLE_OFS)
            st_next.en_reg = cfg_wdata[15:0]; // [R1]
         else if (cfg_addr == `PIN_DIR_OFS)
            st_next.dir_reg = cfg_wdata[15:0]; // [R2]
         else if (cfg_addr == `PIN_VALUE_OFS)
            st_next.val_reg = cfg_wdata[15:0]; // [R5]
         else if (cfg_addr == `RISE_MASK_OFS)
            st_next.rise_mask_reg = cfg_wdata[15:0];
         else if (cfg_addr == `FALL_MASK_OFS)
            st_next.fall_mask_reg = cfg_wdata[15:0];
         else if (cfg_addr == `GLOBAL_CTRL_OFS)
            st_next.gc_reg = cfg_wdata[3:0];
         else if (cfg_addr == `POLARITY_OFS)
            st_next.pol_reg = cfg_wdata[15:0];
      end

      // ------------------------------------------------------------
      // register reads; unmapped addresses answer zero
      // ------------------------------------------------------------
      st_next.ack_reg = cfg_req;
      st_next.rdata_reg = 32'h0000_0000;
      if (cfg_req && !cfg_wr)
      begin
         if (cfg_addr == `PIN_ENABLE_OFS)
            st_next.rdata_reg = {16'h0000, st_reg.en_reg};
         else if (cfg_addr == `PIN_DIR_OFS)
            st_next.rdata_reg = {16'h0000, st_reg.dir_reg};
         else if (cfg_addr == `PIN_VALUE_OFS)
            // outputs read back what they drive, the rest read the pin [R6]
            st_next.rdata_reg = {16'h0000,
               (st_reg.val_reg & out_pins) | (edges.level & ~out_pins)};
         else if (cfg_addr == `RISE_STATUS_OFS)
            st_next.rdata_reg = {16'h0000, st_reg.rise_stat_reg};
         else if (cfg_addr == `RISE_MASK_OFS)
            st_next.rdata_reg = {16'h0000, st_reg.rise_mask_reg};
         else if (cfg_addr == `FALL_STATUS_OFS)
            st_next.rdata_reg = {16'h0000, st_reg.fall_stat_reg};
         else if (cfg_addr == `FALL_MASK_OFS)
            st_next.rdata_reg = {16'h0000, st_reg.fall_mask_reg};
         else if (cfg_addr == `GLOBAL_CTRL_OFS)
            st_next.rdata_reg = {28'h000_0000, st_reg.gc_reg};
         else if (cfg_addr == `POLARITY_OFS)
            st_next.rdata_reg = {16'h0000, st_reg.pol_reg};
      end

      // ------------------------------------------------------------
      // pin drive, from the settings as they will stand next cycle
      // ------------------------------------------------------------
      st_next.out_reg = st_next.val_reg & st_next.en_reg & st_next.dir_reg; // [R5]
      st_next.oe_n_reg = ~(st_next.en_reg & st_next.dir_reg); // [R2] [R3]
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_reg <= '0;
         st_reg.en_reg <= `PIN_ENABLE_RST;
         st_reg.dir_reg <= `PIN_DIR_RST; // [R4]
         st_reg.val_reg <= `PIN_VALUE_RST;
         st_reg.rise_mask_reg <= `MASK_RST;
         st_reg.fall_mask_reg <= `MASK_RST;
         st_reg.pol_reg <= `POLARITY_RST;
         st_reg.gc_reg <= `GLOBAL_CTRL_RST;
         st_reg.oe_n_reg <= 16'hffff; // [R4]
      end
      else
         st_reg <= st_next;
   end

   assign cfg_rdata = st_reg.rdata_reg;
   assign cfg_ack = st_reg.ack_reg;
   assign general_pin_bus_out = st_reg.out_reg;
   assign general_pin_bus_oe_n = st_reg.oe_n_reg;
   assign cpu_irq_req = st_reg.irq_reg;
   assign dma_event_req = st_reg.dma_reg;
endmodule // gpio_port
`default_nettype wire

// *** design/gpio_port_regs.svh ***
// Purpose: register offsets, field positions, reset values and timing counts of the pin port
// Assumes: 20 MHz processor clock, one configuration bus word per register
// Notes:   included by bare name; definitions only
// Function
// R1: sixteen pins, general use only while enabled
// R2: direction zero input, direction one output
// R3: disabled pin ignores its direction bit
// R4: after reset all pins are inputs
// R5: output pin drives last written value bit
// R6: input pin read returns sampled level
// R7: pin activity raises interrupt and dma events
// R8: eight-period input level is always recognised
// R9: polling needs inputs held twelve periods
// R10: delta bits latch edges, masks, polarity
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH

// ------------------------------------------------------------
// register offsets (byte addresses on the configuration bus)
// ------------------------------------------------------------
`define PIN_ENABLE_OFS   32'h01b0_0000
`define PIN_DIR_OFS      32'h01b0_0004
`define PIN_VALUE_OFS    32'h01b0_0008
`define RISE_STATUS_OFS  32'h01b0_0010
`define RISE_MASK_OFS    32'h01b0_0014
`define FALL_STATUS_OFS  32'h01b0_0018
`define FALL_MASK_OFS    32'h01b0_001c
`define GLOBAL_CTRL_OFS  32'h01b0_0020
`define POLARITY_OFS     32'h01b0_0024

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define PIN_ENABLE_RST   16'h0000
`define PIN_DIR_RST      16'h0000
`define PIN_VALUE_RST    16'h0000
`define MASK_RST         16'h0000
`define POLARITY_RST     16'h0000
`define GLOBAL_CTRL_RST  4'h0

// ------------------------------------------------------------
// global control fields
// ------------------------------------------------------------
`define GC_MODE_LSB      0
`define GC_MODE_MSB      1
`define GC_DMA_EN_BIT    2
`define GC_IRQ_EN_BIT    3

// ------------------------------------------------------------
// timing, in processor clock periods
// ------------------------------------------------------------
`define MIN_EVENT_PULSE_P 8
`define MIN_POLL_PULSE_P  12

`endif

// *** design/gpio_port_pkg.sv ***
// Purpose: shared types of the pin port
// Assumes: constants live in gpio_port_regs.svh
// Notes:   none
package gpio_port_pkg;
   typedef logic [15:0] pins_t;

   typedef enum logic [1:0]
   {
      MODE_PASS = 2'b00,
      MODE_OR   = 2'b01,
      MODE_AND  = 2'b10
   } event_mode_e;

   typedef struct packed
   {
      pins_t level;
      pins_t prev;
      pins_t rise;
      pins_t fall;
   } detect_state_s;

   typedef struct packed
   {
      pins_t en_reg;
      pins_t dir_reg;
      pins_t val_reg;
      pins_t rise_stat_reg;
      pins_t rise_mask_reg;
      pins_t fall_stat_reg;
      pins_t fall_mask_reg;
      pins_t pol_reg;
      logic [3:0] gc_reg;
      logic cond_prev_reg;
      logic [31:0] rdata_reg;
      logic ack_reg;
      pins_t out_reg;
      pins_t oe_n_reg;
      logic irq_reg;
      logic dma_reg;
   } port_state_s;
endpackage

// *** design/pin_edge_if.sv ***
// Purpose: carries sampled levels and edge pulses from the detector to the port
// Assumes: one clock domain
// Notes:   none
`timescale 1ns/100ps
`default_nettype none
interface pin_edge_if;
   import gpio_port_pkg::*;
   pins_t level;
   pins_t rise;
   pins_t fall;
   modport det (output level, output rise, output fall);
   modport use_side (input level, input rise, input fall);
endinterface
`default_nettype wire

// *** design/pin_edge_detect.sv ***
// Purpose: samples the pins and flags rising and falling edges
// Assumes: pin inputs are synchronous to clk
// Notes:   one sample per clock, so any level of eight periods is caught
`timescale 1ns/100ps
`default_nettype none
module pin_edge_detect
   import gpio_port_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire pins_t pin_in,
   pin_edge_if.det edges
);
   detect_state_s st_reg;
   detect_state_s st_next;

   always_comb
   begin
      st_next = st_reg;
      st_next.level = pin_in;
      st_next.prev = st_reg.level;
      // every clock samples, so short limits are met with margin [R8]
      st_next.rise = pin_in & ~st_reg.level;
      st_next.fall = ~pin_in & st_reg.level;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign edges.level = st_reg.level;
   assign edges.rise = st_reg.rise;
   assign edges.fall = st_reg.fall;
endmodule // pin_edge_detect
`default_nettype wire

// *** tb/gpio_port_checker.sv ***
// Purpose: port assertions of the pin port
// Assumes: one clock, rstn active low
// Notes:   attached to the port by bind
`timescale 1ns/100ps
`default_nettype none
module gpio_port_checker (
   input wire logic clk,
   input wire logic rstn,
   input wire logic cfg_req,
   input wire logic cfg_wr,
   input wire logic [31:0] cfg_addr,
   input wire logic [31:0] cfg_wdata,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_ack,
   input wire logic [15:0] general_pin_bus_in,
   input wire logic [15:0] general_pin_bus_out,
   input wire logic [15:0] general_pin_bus_oe_n,
   input wire logic cpu_irq_req,
   input wire logic dma_event_req
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_write; cfg_req && cfg_wr; endsequence
   sequence s_resv_read; cfg_req && !cfg_wr && cfg_addr == 32'h01b0_000c; endsequence
   sequence s_answer; cfg_ack && cfg_rdata == 32'h0000_0000; endsequence
   chk_ack_follows: assert property (cfg_req |=> cfg_ack)
      else $error("request not acknowledged");
   chk_ack_idle: assert property (!cfg_req |=> !cfg_ack)
      else $error("acknowledge without request");
   chk_rdata_idle: assert property (!cfg_ack |-> cfg_rdata == 32'h0000_0000)
      else $error("read data outside answer");
   chk_write_no_data: assert property (s_write |=> s_answer)
      else $error("write answered with data");
   chk_resv_read: assert property (s_resv_read |=> s_answer)
      else $error("reserved word not zero");
   chk_undriven_low: assert property ((general_pin_bus_out & general_pin_bus_oe_n) == 16'h0000)
      else $error("level on undriven pin");
   chk_reset_inputs: assert property ($rose(rstn) |-> general_pin_bus_oe_n == 16'hffff)
      else $error("pin driven after reset");
   chk_drive_by_write: assert property ($changed(general_pin_bus_oe_n) |-> cfg_ack && $past(cfg_wr))
      else $error("drive changed without write");
endmodule // gpio_port_checker
bind gpio_port gpio_port_checker chk (.clk(clk), .rstn(rstn), .cfg_req(cfg_req),
   .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
   .cfg_ack(cfg_ack), .general_pin_bus_in(general_pin_bus_in),
   .general_pin_bus_out(general_pin_bus_out), .general_pin_bus_oe_n(general_pin_bus_oe_n),
   .cpu_irq_req(cpu_irq_req), .dma_event_req(dma_event_req));
`default_nettype wire

// *** tb/pin_world.sv ***
// Purpose: outside circuit on the sixteen pins
// Assumes: levels change just after a clock edge
// Notes:   no pull resistors, so the outside always drives
`timescale 1ns/100ps
`default_nettype none
module pin_world (
   input wire logic clk,
   input wire logic [15:0] general_pin_bus_out,
   input wire logic [15:0] general_pin_bus_oe_n,
   output logic [15:0] general_pin_bus_in
);
   logic [15:0] ext_level = 16'h0000;
   // a pin the device drives shows its level, the others show the outside drive
   assign general_pin_bus_in = (general_pin_bus_out & ~general_pin_bus_oe_n)
      | (ext_level & general_pin_bus_oe_n);
   task automatic hold_level(input logic [15:0] lvl);
      @(posedge clk);
      ext_level <= lvl;
      repeat (12) @(posedge clk);
   endtask
endmodule // pin_world
`default_nettype wire

// *** tb/general_purpose_pin_port_bench.sv ***
// Purpose: self-checking bench of the pin port
// Assumes: 20 MHz clk, pin levels held 12 cycles
// Notes:   register rows first, then pin and event tests
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port_regs.svh"
module general_purpose_pin_port_bench;
   typedef struct {logic w; logic [31:0] a; logic [31:0] d; logic [31:0] e;} row_s;
   logic clk, rstn, req, wr, ack, irq, dma;
   logic [31:0] addr, wdata, rdata, rd;
   logic [15:0] pin_in, pin_out, oe_n;
   int n_fail = 0, n_compared = 0, n_irq = 0, n_dma = 0, bi, bd;
   row_s rows [7] = '{'{1'b0, `PIN_ENABLE_OFS, '0, '0}, '{1'b0, `PIN_DIR_OFS, '0, '0},
      '{1'b1, 32'h01b0_000c, 32'hffff_ffff, '0}, '{1'b0, 32'h01b0_000c, '0, '0},
      '{1'b0, 32'h01b0_0028, '0, '0}, '{1'b1, `POLARITY_OFS, 32'hffff_1234, '0},
      '{1'b0, `POLARITY_OFS, '0, 32'h0000_1234}};
   gpio_port dut (.clk(clk), .rstn(rstn), .cfg_req(req), .cfg_wr(wr), .cfg_addr(addr),
      .cfg_wdata(wdata), .cfg_rdata(rdata), .cfg_ack(ack), .general_pin_bus_in(pin_in),
      .general_pin_bus_out(pin_out), .general_pin_bus_oe_n(oe_n), .cpu_irq_req(irq),
      .dma_event_req(dma));
   pin_world world (.clk(clk), .general_pin_bus_out(pin_out),
      .general_pin_bus_oe_n(oe_n), .general_pin_bus_in(pin_in));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one request cycle; the answer is taken in the cycle after it
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= 1'b1;
      wr <= w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      req <= 1'b0;
      #1;
      check("ack", 32'(ack), 32'h0000_0001);
      rd = rdata;
   endtask
   task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
      bus(1'b0, a, '0);
      check("register", rd, e);
   endtask
   task automatic print_verdict();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk)
   begin
      n_irq <= n_irq + int'(irq === 1'b1);
      n_dma <= n_dma + int'(dma === 1'b1);
   end
   initial
   begin
      #100us;
      n_fail++;
      print_verdict();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      rstn <= 1'b0;
      req <= 1'b0;
      wr <= 1'b0;
      addr <= 32'h0000_0000;
      wdata <= 32'h0000_0000;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      foreach (rows[i])
      begin
         bus(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w)
            check("row", rd, rows[i].e);
      end
      $display("register rows done");
      world.hold_level(16'ha5a0);
      wr_reg(`PIN_ENABLE_OFS, 32'h0000_00ff);
      wr_reg(`PIN_DIR_OFS, 32'h0000_0f0f);
      wr_reg(`PIN_VALUE_OFS, 32'h0000_ffff);
      check("oe_n", 32'(oe_n), 32'h0000_fff0);
      check("out", 32'(pin_out), 32'h0000_000f);
      rd_chk(`PIN_VALUE_OFS, 32'h0000_a5af);
      $display("direction test done");
      wr_reg(`POLARITY_OFS, '0);
      wr_reg(`PIN_DIR_OFS, '0);
      wr_reg(`PIN_ENABLE_OFS, 32'h0000_ffff);
      world.hold_level(16'h0002);
      wr_reg(`RISE_MASK_OFS, 32'h0000_0001);
      wr_reg(`FALL_MASK_OFS, 32'h0000_0002);
      wr_reg(`RISE_STATUS_OFS, 32'h0000_ffff);
      wr_reg(`FALL_STATUS_OFS, 32'h0000_ffff);
      wr_reg(`GLOBAL_CTRL_OFS, 32'h0000_000c);
      bi = n_irq;
      bd = n_dma;
      world.hold_level(16'h0003);
      world.hold_level(16'h0001);
      world.hold_level(16'h0005);
      check("irq", 32'(n_irq - bi), 32'h0000_0002);
      check("dma", 32'(n_dma - bd), 32'h0000_0002);
      rd_chk(`RISE_STATUS_OFS, 32'h0000_0005);
      rd_chk(`FALL_STATUS_OFS, 32'h0000_0002);
      wr_reg(`RISE_STATUS_OFS, 32'h0000_0001);
      rd_chk(`RISE_STATUS_OFS, 32'h0000_0004);
      $display("pass mode test done");
      world.hold_level(16'h0000);
      wr_reg(`RISE_MASK_OFS, 32'h0000_0003);
      wr_reg(`GLOBAL_CTRL_OFS, 32'h0000_0009);
      bi = n_irq;
      world.hold_level(16'h0001);
      check("or mode", 32'(n_irq - bi), 32'h0000_0001);
      world.hold_level(16'h0003);
      world.hold_level(16'h0000);
      wr_reg(`GLOBAL_CTRL_OFS, 32'h0000_000a);
      world.hold_level(16'h0001);
      check("and mode", 32'(n_irq - bi), 32'h0000_0001);
      world.hold_level(16'h0003);
      check("and mode", 32'(n_irq - bi), 32'h0000_0002);
      // inverted sense on pin 0: level 2 then reads as both selected pins active
      wr_reg(`POLARITY_OFS, 32'h0000_0001);
      world.hold_level(16'h0002);
      check("polarity", 32'(n_irq - bi), 32'h0000_0003);
      check("dma off", 32'(n_dma - bd), 32'h0000_0002);
      $display("mode test done");
      // drive every pin first so that the reset has something to undo
      wr_reg(`PIN_DIR_OFS, 32'h0000_ffff);
      check("oe_n driven", 32'(oe_n), 32'h0000_0000);
      @(posedge clk);
      rstn <= 1'b0;
      repeat (5) @(posedge clk);
      check("oe_n reset", 32'(oe_n), 32'h0000_ffff);
      check("out reset", 32'(pin_out), 32'h0000_0000);
      rstn <= 1'b1;
      rd_chk(`PIN_DIR_OFS, '0);
      rd_chk(`PIN_ENABLE_OFS, '0);
      $display("reset test done");
      print_verdict();
   end
endmodule // general_purpose_pin_port_bench
`default_nettype wire
